// ---- common/remap_par_map.svh ----
// Register map constants for the per-bank remap, result and monitor mirror registers.
// Assumes a word-addressed plain register port; one bank window per context bank.
`ifndef REMAP_PAR_MAP_SVH
`define REMAP_PAR_MAP_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_BANKS 4
`define BANK_SEL_W 2
`define ADDR_W 8
`define REG_IDX_W 4

// ----------------------------------------
// Register offsets inside a bank window (word indices)
// ----------------------------------------
`define OFF_REMAP 4'h0
`define OFF_RESULT_LO 4'h1
`define OFF_RESULT_HI 4'h2
`define OFF_AUTH_STATUS 4'h3
`define OFF_EVENT_ID_LOW 4'h4
`define OFF_EVENT_ID_HIGH 4'h5
`define OFF_CTRL 4'h6
`define OFF_IRQ_STATUS 4'h7
`define OFF_IRQ_ENABLE 4'h8
`define OFF_IRQ_CLEAR 4'h9

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_EXT_ADDR_BIT 0
`define CTRL_COUNTER_REVEAL_BIT 1
`define CTRL_SECURE_BANK_BIT 2

// ----------------------------------------
// Result register fields and the implementation-specific remap inner index
// ----------------------------------------
`define RES_FAULT_BIT 0
`define RES_SUPERSECTION_BIT 1
`define RES_LONG_ONE_BIT 11
`define RES_NS_BIT 9
`define RES_FAULT_AFF_BIT 1
`define RES_FAULT_TF_BIT 2
`define REMAP_INNER_IMPDEF_IDX 6

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_DONE_BIT 0
`define IRQ_FAULT_BIT 1
`define IRQ_W 2

// ----------------------------------------
// Reset and unknown-read values (architecturally unpredictable; zero chosen)
// ----------------------------------------
`define RESET_WORD 32'h0000_0000
`define UNK_WORD 32'h0000_0000

`endif

// ---- common/remap_par_pkg.sv ----
// Types shared by the per-bank remap and result register block.
// Assumes the constants header is included alongside.
package remap_par_pkg;
  // Cacheability encodings used by the remap fields
  typedef enum logic [1:0] {
    REMAP_NC = 2'h0,
    REMAP_WB_WA = 2'h1,
    REMAP_WT = 2'h2,
    REMAP_WB_NOWA = 2'h3
  } remap_cache_t;
  // Cacheability encodings reported in the short success result
  typedef enum logic [1:0] {
    RES_WB_NOWA = 2'h0,
    RES_WT = 2'h1,
    RES_WB_WA = 2'h2,
    RES_NC = 2'h3
  } result_cache_t;
  // Translation completion handler states
  typedef enum logic [1:0] {
    WALK_IDLE,
    WALK_CAPTURE
  } walk_state_t;
endpackage

// ---- hw/remap_par_regs.sv ----
// Per-context-bank remap, translation result and monitor mirror registers.
// Assumes a translation walker presents one completion pulse with its result fields,
// and a single-cycle register port with read data one cycle after the read strobe.
//
// Notes on behaviour
// - Remap register exists only when the bank selects short tables.
// - Remap register is 32-bit read-write; reset value is undefined.
// - Outer fields in bits 31:16, indexed by TEX0,C,B, used for Normal regions.
// - Remap field codes: 00 NC, 01 WB-WA, 10 WT, 11 WB no-WA.
// - Inner fields in bits 15:0, indexed and encoded like outer fields.
// - Inner field 6 may carry an implementation-specific meaning.
// - Result register is 64-bit read-write; layout set by format and outcome.
// - Short success, supersection clear: PA 31:12 lands in bits 31:12.
// - Supersection set: PA 31:24, PA 39:32 in 23:16, zeros in 15:12.
// - Short result cache codes: 00 WB, 01 WT, 10 WB-WA, 11 NC.
// - Bit 0 is clear on success and set when translation aborts.
// - Long success: attribute byte 63:56, PA 39:12, shareability 8:7.
// - Long success layout always returns one in bit 11.
// - Bit 9 gives the entry's non-secure attribute for secure banks.
// - Fault layout is shared; flags access flag and translation faults.
// - Auth status mirrors monitor format when revealed, else unknown, writes ignored.
// - Two read-only event id registers mirror monitors when revealed.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "remap_par_map.svh"

module remap_par_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Translation completion from the walker
  input wire logic i_walk_done,
  input wire logic [`BANK_SEL_W-1:0] i_walk_bank,
  input wire logic i_walk_fault,
  input wire logic i_walk_supersection,
  input wire logic [39:12] i_walk_pa,
  input wire logic [1:0] i_walk_cache,
  input wire logic [7:0] i_walk_memory_attr_byte,
  input wire logic [1:0] i_walk_share,
  input wire logic i_walk_ns,
  input wire logic i_walk_access_fault,
  input wire logic i_walk_trans_fault,
  // Remap lookup by the walker
  input wire logic [`BANK_SEL_W-1:0] i_lookup_bank,
  input wire logic [2:0] i_lookup_index,
  input wire logic i_lookup_normal,
  output remap_par_pkg::remap_cache_t o_lookup_outer,
  output remap_par_pkg::remap_cache_t o_lookup_inner,
  output logic o_lookup_valid,
  output logic o_lookup_impdef,
  // Shared monitor state mirrored into revealed banks
  input wire logic [31:0] i_mon_auth_status,
  input wire logic [31:0] i_mon_event_id_low,
  input wire logic [31:0] i_mon_event_id_high,
  // Interrupt
  output logic o_irq
);
  import remap_par_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Address bits above the bank field are ignored, so banks alias upward
  wire [`BANK_SEL_W-1:0] acc_bank = i_addr[`REG_IDX_W+`BANK_SEL_W-1:`REG_IDX_W];
  wire [`REG_IDX_W-1:0] acc_reg = i_addr[`REG_IDX_W-1:0];

  logic [31:0] bank_rdata [`NUM_BANKS];
  logic [`NUM_BANKS-1:0] bank_irq;
  remap_cache_t bank_outer [`NUM_BANKS];
  remap_cache_t bank_inner [`NUM_BANKS];
  logic [`NUM_BANKS-1:0] bank_short;
  // Flat copy of the reveal bits; generate scopes cannot be picked by a run-time index
  logic [`NUM_BANKS-1:0] bank_revealed;
  walk_state_t state;
  logic cap_valid;
  logic [`BANK_SEL_W-1:0] cap_bank;
  logic cap_fault, cap_ss, cap_ns, cap_aff, cap_tf;
  logic [39:12] cap_pa;
  logic [1:0] cap_cache, cap_share;
  logic [7:0] cap_memory_attr_byte;

  // ----------------------------------------
  // Completion capture; one cycle of staging keeps the result write clean
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= WALK_IDLE;
    end else begin
      case (state)
        WALK_IDLE: state <= i_walk_done ? WALK_CAPTURE : WALK_IDLE;
        WALK_CAPTURE: state <= i_walk_done ? WALK_CAPTURE : WALK_IDLE;
        default: state <= WALK_IDLE;
      endcase
    end
  end
  assign cap_valid = (state == WALK_CAPTURE);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_bank <= '0;
      cap_fault <= 1'b0;
      cap_ss <= 1'b0;
      cap_ns <= 1'b0;
      cap_aff <= 1'b0;
      cap_tf <= 1'b0;
      cap_pa <= '0;
      cap_cache <= 2'h0;
      cap_share <= 2'h0;
      cap_memory_attr_byte <= 8'h00;
    end else if (i_walk_done) begin
      cap_bank <= i_walk_bank;
      cap_fault <= i_walk_fault;
      cap_ss <= i_walk_supersection;
      cap_ns <= i_walk_ns;
      cap_aff <= i_walk_access_fault;
      cap_tf <= i_walk_trans_fault;
      cap_pa <= i_walk_pa;
      cap_cache <= i_walk_cache;
      cap_share <= i_walk_share;
      cap_memory_attr_byte <= i_walk_memory_attr_byte;
    end
  end

  // ----------------------------------------
  // Per-bank register copies
  // ----------------------------------------
  generate
    for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
      logic [31:0] remap;
      logic [63:0] result;
      logic [2:0] ctrl;
      logic [`IRQ_W-1:0] irq_stat, irq_en;
      wire sel = (acc_bank == `BANK_SEL_W'(b));
      wire wr_here = i_wr && sel;
      wire ext_addr = ctrl[`CTRL_EXT_ADDR_BIT];
      wire revealed = ctrl[`CTRL_COUNTER_REVEAL_BIT];
      wire secure_bank = ctrl[`CTRL_SECURE_BANK_BIT];
      wire cap_here = cap_valid && (cap_bank == `BANK_SEL_W'(b));
      // Short success layout
      wire [31:12] short_pa = cap_ss ?
        {cap_pa[31:24], cap_pa[39:32], 4'h0} : cap_pa[31:12];
      wire [31:0] short_word = {short_pa, 6'h00, cap_cache, 2'h0,
        cap_ss, 1'b0};
      // Long success layout; bit 9 forced low for non-secure banks
      wire [63:0] long_word = {cap_memory_attr_byte, 16'h0000, cap_pa[39:12], 1'b1, 1'b0,
        cap_ns && secure_bank, cap_share, 6'h00, 1'b0};
      // Fault layout, same for both formats
      wire [63:0] fault_word = {61'h0, cap_tf, cap_aff, 1'b1};
      wire [63:0] next_result = cap_fault ? fault_word :
        (ext_addr ? long_word : {32'h0000_0000, short_word});
      wire [`IRQ_W-1:0] irq_set = cap_here ?
        {cap_fault, !cap_fault} : '0;

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          remap <= `RESET_WORD;
          ctrl <= 3'h0;
        end else begin
          if (wr_here && acc_reg == `OFF_REMAP && !ext_addr)
            remap <= i_wdata;
          if (wr_here && acc_reg == `OFF_CTRL)
            ctrl <= i_wdata[2:0];
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          result <= 64'h0000_0000_0000_0000;
        end else if (cap_here) begin
          result <= next_result;
        end else if (wr_here && acc_reg == `OFF_RESULT_LO) begin
          result[31:0] <= i_wdata;
        end else if (wr_here && acc_reg == `OFF_RESULT_HI) begin
          result[63:32] <= i_wdata;
        end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          irq_stat <= '0;
          irq_en <= '0;
        end else begin
          irq_stat <= (irq_stat & ~((wr_here && acc_reg == `OFF_IRQ_CLEAR) ?
            i_wdata[`IRQ_W-1:0] : '0)) | irq_set;
          if (wr_here && acc_reg == `OFF_IRQ_ENABLE)
            irq_en <= i_wdata[`IRQ_W-1:0];
        end
      end
      assign bank_irq[b] = |(irq_stat & irq_en);
      assign bank_short[b] = !ext_addr;
      assign bank_revealed[b] = revealed;

      // Remap lookup for Normal regions only
      assign bank_outer[b] = remap_cache_t'(remap[16+2*i_lookup_index +: 2]);
      assign bank_inner[b] = remap_cache_t'(remap[2*i_lookup_index +: 2]);

      // Monitor mirrors: unknown reads as zero, writes have no decode
      wire [31:0] auth_rd = revealed ? i_mon_auth_status : `UNK_WORD;
      wire [31:0] id_lo_rd = revealed ? i_mon_event_id_low : `UNK_WORD;
      wire [31:0] id_hi_rd = revealed ? i_mon_event_id_high : `UNK_WORD;

      always_comb begin
        case (acc_reg)
          `OFF_REMAP: bank_rdata[b] = ext_addr ? 32'h0000_0000 : remap;
          `OFF_RESULT_LO: bank_rdata[b] = result[31:0];
          `OFF_RESULT_HI: bank_rdata[b] = result[63:32];
          `OFF_AUTH_STATUS: bank_rdata[b] = auth_rd;
          `OFF_EVENT_ID_LOW: bank_rdata[b] = id_lo_rd;
          `OFF_EVENT_ID_HIGH: bank_rdata[b] = id_hi_rd;
          `OFF_CTRL: bank_rdata[b] = {29'h0, ctrl};
          `OFF_IRQ_STATUS: bank_rdata[b] = {30'h0, irq_stat};
          `OFF_IRQ_ENABLE: bank_rdata[b] = {30'h0, irq_en};
          default: bank_rdata[b] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------
  // Lookup and read return
  // ----------------------------------------
  assign o_lookup_valid = i_lookup_normal && bank_short[i_lookup_bank];
  assign o_lookup_outer = o_lookup_valid ? bank_outer[i_lookup_bank] : REMAP_NC;
  assign o_lookup_inner = o_lookup_valid ? bank_inner[i_lookup_bank] : REMAP_NC;
  // Index 6 is flagged so a consumer can apply its own meaning
  assign o_lookup_impdef = o_lookup_valid &&
    (i_lookup_index == 3'(`REMAP_INNER_IMPDEF_IDX));
  assign o_irq = |bank_irq;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      o_rdata <= 32'h0000_0000;
    else
      o_rdata <= i_rd ? bank_rdata[acc_bank] : 32'h0000_0000;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  fault_bit_set_a: assert property (
    i_walk_done && i_walk_fault && i_walk_bank == 2'h0 ##1 1'b1 ##1 !i_walk_done
    |=> g_bank[0].result[0] == 1'b1)
    else $error("fault completion did not set bit 0");
  success_bit_clr_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h0 |=> g_bank[0].result[0] == 1'b0)
    else $error("success completion left bit 0 set");
  long_bit11_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h1 && g_bank[1].ext_addr
    |=> g_bank[1].result[11])
    else $error("long layout bit 11 not one");
  super_low_zero_a: assert property (
    cap_valid && !cap_fault && cap_ss && cap_bank == 2'h0 && !g_bank[0].ext_addr
    |=> g_bank[0].result[15:12] == 4'h0 && g_bank[0].result[1])
    else $error("supersection low bits not zero");
  short_pa_copy_a: assert property (
    cap_valid && !cap_fault && !cap_ss && cap_bank == 2'h0 && !g_bank[0].ext_addr
    |=> g_bank[0].result[31:12] == $past(cap_pa[31:12]))
    else $error("short result address mismatch");
  remap_gate_a: assert property (
    i_rd && acc_reg == `OFF_REMAP && !bank_short[acc_bank] |=> o_rdata == 32'h0000_0000)
    else $error("remap visible with long tables");
  auth_hidden_a: assert property (
    i_rd && acc_reg == `OFF_AUTH_STATUS && !bank_revealed[acc_bank]
    |=> o_rdata == `UNK_WORD)
    else $error("hidden auth status not masked");
  event_id_mirror_a: assert property (
    i_rd && acc_reg == `OFF_EVENT_ID_LOW && bank_revealed[acc_bank]
    |=> o_rdata == $past(i_mon_event_id_low))
    else $error("event id mirror mismatch");
  fault_flags_a: assert property (
    cap_valid && cap_fault && cap_bank == 2'h2
    |=> g_bank[2].result[2:1] == $past({cap_tf, cap_aff}))
    else $error("fault flags wrong");

  // ----------------------------------------
  // Bus, capture, lookup, remap, layout, interrupt and mirror checks
  // ----------------------------------------
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  capture_next_a: assert property (i_walk_done |=> cap_valid)
    else $error("completion not staged");
  capture_end_a: assert property (!i_walk_done |=> !cap_valid)
    else $error("staging held too long");
  lookup_off_a: assert property (
    !o_lookup_valid |-> o_lookup_outer == REMAP_NC && o_lookup_inner == REMAP_NC)
    else $error("lookup fields not idle");
  impdef_index_a: assert property (
    o_lookup_impdef |-> o_lookup_valid && i_lookup_index == 3'h6)
    else $error("impdef flag on wrong index");
  lookup_long_a: assert property (
    i_lookup_normal && !bank_short[i_lookup_bank] |-> !o_lookup_valid)
    else $error("lookup valid with long tables");
  remap_lock0_a: assert property (g_bank[0].ext_addr |=> $stable(g_bank[0].remap))
    else $error("remap bank 0 written in long mode");
  remap_lock1_a: assert property (g_bank[1].ext_addr |=> $stable(g_bank[1].remap))
    else $error("remap bank 1 written in long mode");
  remap_lock2_a: assert property (g_bank[2].ext_addr |=> $stable(g_bank[2].remap))
    else $error("remap bank 2 written in long mode");
  remap_lock3_a: assert property (g_bank[3].ext_addr |=> $stable(g_bank[3].remap))
    else $error("remap bank 3 written in long mode");
  remap_write_a: assert property (
    i_wr && acc_reg == `OFF_REMAP && acc_bank == 2'h0 && bank_short[0]
    |=> g_bank[0].remap == $past(i_wdata))
    else $error("remap write lost");
  short_upper_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h0 && !g_bank[0].ext_addr
    |=> g_bank[0].result[63:32] == 32'h0000_0000)
    else $error("short result upper word not zero");
  short_cache_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h0 && !g_bank[0].ext_addr
    |=> g_bank[0].result[5:4] == $past(cap_cache))
    else $error("short cache code wrong");
  super_map_a: assert property (
    cap_valid && !cap_fault && cap_ss && cap_bank == 2'h0 && !g_bank[0].ext_addr
    |=> g_bank[0].result[23:16] == $past(cap_pa[39:32])
    && g_bank[0].result[31:24] == $past(cap_pa[31:24]))
    else $error("supersection address mix wrong");
  fault_layout_a: assert property (
    cap_valid && cap_fault && cap_bank == 2'h0
    |=> g_bank[0].result[2:0] == {$past({cap_tf, cap_aff}), 1'b1})
    else $error("fault layout wrong");
  long_pa_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h1 && g_bank[1].ext_addr
    |=> g_bank[1].result[39:12] == $past(cap_pa)
    && g_bank[1].result[63:56] == $past(cap_memory_attr_byte))
    else $error("long address or attribute wrong");
  long_share_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h1 && g_bank[1].ext_addr
    |=> g_bank[1].result[8:7] == $past(cap_share) && g_bank[1].result[55:40] == 16'h0000)
    else $error("long share or reserved bits wrong");
  secure_ns_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h1 && g_bank[1].ext_addr
    && g_bank[1].secure_bank |=> g_bank[1].result[9] == $past(cap_ns))
    else $error("secure bank ns bit wrong");
  nonsec_ns_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h3 && g_bank[3].ext_addr
    && !g_bank[3].secure_bank |=> !g_bank[3].result[9])
    else $error("non-secure bank ns bit set");
  result_write_a: assert property (
    i_wr && acc_reg == `OFF_RESULT_LO && acc_bank == 2'h2 && !(cap_valid && cap_bank == 2'h2)
    |=> g_bank[2].result[31:0] == $past(i_wdata))
    else $error("result low word write lost");
  bank_indep_a: assert property (
    cap_valid && cap_bank != 2'h2 && !(i_wr && acc_bank == 2'h2)
    |=> $stable(g_bank[2].result))
    else $error("result of another bank disturbed");
  irq_done_a: assert property (
    cap_valid && !cap_fault && cap_bank == 2'h0 |=> g_bank[0].irq_stat[`IRQ_DONE_BIT])
    else $error("done status not set");
  irq_fault_a: assert property (
    cap_valid && cap_fault && cap_bank == 2'h0 |=> g_bank[0].irq_stat[`IRQ_FAULT_BIT])
    else $error("fault status not set");
  irq_clear_a: assert property (
    i_wr && acc_reg == `OFF_IRQ_CLEAR && acc_bank == 2'h0 && !(cap_valid && cap_bank == 2'h0)
    |=> (g_bank[0].irq_stat & $past(i_wdata[1:0])) == 2'h0)
    else $error("status clear ignored");
  auth_shown_a: assert property (
    i_rd && acc_reg == `OFF_AUTH_STATUS && bank_revealed[acc_bank]
    |=> o_rdata == $past(i_mon_auth_status))
    else $error("auth status mirror mismatch");
  event_high_a: assert property (
    i_rd && acc_reg == `OFF_EVENT_ID_HIGH && bank_revealed[acc_bank]
    |=> o_rdata == $past(i_mon_event_id_high))
    else $error("event id high mirror mismatch");
  event_hidden_a: assert property (
    i_rd && (acc_reg == `OFF_EVENT_ID_LOW || acc_reg == `OFF_EVENT_ID_HIGH)
    && !bank_revealed[acc_bank] |=> o_rdata == `UNK_WORD)
    else $error("hidden event id not masked");
  unmapped_read_a: assert property (
    i_rd && acc_reg > `OFF_IRQ_ENABLE |=> o_rdata == 32'h0000_0000)
    else $error("unmapped index read not zero");

  cover_fault_c: cover property (cap_valid && cap_fault);
  cover_super_c: cover property (cap_valid && cap_ss && !cap_fault);
  cover_irq_c: cover property (o_irq);
  cover_lookup_c: cover property (o_lookup_valid && o_lookup_impdef);
endmodule // remap_par_regs

// ---- testbench/tb_top.sv ----
// Self-checking bench for the per-bank remap, translation result and monitor mirror registers.
// Assumes the map header and package are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`include "remap_par_map.svh"

module tb_top;
  import remap_par_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic i_clk, i_rst_b, i_wr, i_rd, i_walk_done, i_walk_fault, i_walk_supersection;
  logic i_walk_ns, i_walk_access_fault, i_walk_trans_fault, i_lookup_normal;
  logic o_lookup_valid, o_lookup_impdef, o_irq;
  logic [`ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_mon_auth_status, i_mon_event_id_low, i_mon_event_id_high;
  logic [`BANK_SEL_W-1:0] i_walk_bank, i_lookup_bank;
  logic [39:12] i_walk_pa;
  logic [1:0] i_walk_cache, i_walk_share;
  logic [7:0] i_walk_memory_attr_byte;
  logic [2:0] i_lookup_index;
  remap_cache_t o_lookup_outer, o_lookup_inner;
  remap_cache_t codes [4];
  logic [31:0] v;
  logic [39:12] pa_v;
  int err_total;
  int comparisons;

  remap_par_regs dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_walk_done(i_walk_done), .i_walk_bank(i_walk_bank),
    .i_walk_fault(i_walk_fault), .i_walk_supersection(i_walk_supersection),
    .i_walk_pa(i_walk_pa), .i_walk_cache(i_walk_cache), .i_walk_memory_attr_byte(i_walk_memory_attr_byte),
    .i_walk_share(i_walk_share), .i_walk_ns(i_walk_ns),
    .i_walk_access_fault(i_walk_access_fault), .i_walk_trans_fault(i_walk_trans_fault),
    .i_lookup_bank(i_lookup_bank), .i_lookup_index(i_lookup_index),
    .i_lookup_normal(i_lookup_normal), .o_lookup_outer(o_lookup_outer),
    .o_lookup_inner(o_lookup_inner), .o_lookup_valid(o_lookup_valid),
    .o_lookup_impdef(o_lookup_impdef), .i_mon_auth_status(i_mon_auth_status),
    .i_mon_event_id_low(i_mon_event_id_low), .i_mon_event_id_high(i_mon_event_id_high),
    .o_irq(o_irq)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  // Strobes drop a cycle before the next request so no signal is driven twice per step
  task wr(input logic [1:0] b, input logic [3:0] r, input logic [31:0] d);
    i_addr <= {2'b00, b, r};
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task rc(input logic [1:0] b, input logic [3:0] r, input logic [31:0] e);
    i_addr <= {2'b00, b, r};
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("rdata_%h", {b, r}), o_rdata, e);
    @(posedge i_clk);
  endtask

  // Result lands at the second edge after the completion pulse
  task walk(input logic [1:0] b, input logic f, input logic s);
    i_walk_bank <= b;
    i_walk_fault <= f;
    i_walk_supersection <= s;
    i_walk_done <= 1'b1;
    @(posedge i_clk);
    i_walk_done <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_wr, i_rd, i_walk_done, i_walk_fault, i_walk_supersection, i_walk_ns} = '0;
    {i_walk_access_fault, i_walk_trans_fault, i_lookup_normal, i_lookup_index} = '0;
    {i_addr, i_wdata, i_walk_bank, i_lookup_bank, i_walk_cache, i_walk_share} = '0;
    i_walk_memory_attr_byte = 8'h4F;
    pa_v = 28'h9A5_C3E7;
    i_walk_pa = pa_v;
    i_mon_auth_status = 32'hC0DE_0011;
    i_mon_event_id_low = 32'h1357_9BDF;
    i_mon_event_id_high = 32'h2468_ACE0;
    codes = '{REMAP_NC, REMAP_WB_WA, REMAP_WT, REMAP_WB_NOWA};
    i_rst_b = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rc(0, `OFF_REMAP, 32'h0000_0000);
    rc(0, `OFF_RESULT_LO, 32'h0000_0000);
    // Bank 0 short, 1 long secure, 2 revealed, 3 long non-secure
    wr(0, `OFF_CTRL, 32'h0000_0000);
    wr(1, `OFF_CTRL, 32'h0000_0005);
    wr(2, `OFF_CTRL, 32'h0000_0002);
    wr(3, `OFF_CTRL, 32'h0000_0001);
    for (int m = 0; m < 8; m++) begin
      v[16+2*m +: 2] = m[1:0];
      v[2*m +: 2] = ~m[1:0];
    end
    wr(0, `OFF_REMAP, v);
    rc(0, `OFF_REMAP, v);
    wr(1, `OFF_REMAP, v);
    rc(1, `OFF_REMAP, 32'h0000_0000);
    i_lookup_normal <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      i_lookup_index <= m[2:0];
      @(posedge i_clk);
      chk("outer", o_lookup_outer, codes[m % 4]);
      chk("inner", o_lookup_inner, codes[3 - (m % 4)]);
      chk("valid", o_lookup_valid, 1'b1);
      chk("impdef", o_lookup_impdef, m == `REMAP_INNER_IMPDEF_IDX);
    end
    i_lookup_normal <= 1'b0;
    @(posedge i_clk);
    chk("valid_dev", o_lookup_valid, 1'b0);
    i_lookup_normal <= 1'b1;
    i_lookup_bank <= 2'd1;
    @(posedge i_clk);
    chk("valid_long", o_lookup_valid, 1'b0);
    // Every short cache code, then a supersection
    for (int c = 0; c < 4; c++) begin
      i_walk_cache <= c[1:0];
      walk(0, 1'b0, 1'b0);
      rc(0, `OFF_RESULT_LO, {pa_v[31:12], 6'h00, c[1:0], 4'h0});
    end
    i_walk_cache <= RES_WB_WA;
    walk(0, 1'b0, 1'b1);
    rc(0, `OFF_RESULT_LO, {pa_v[31:24], pa_v[39:32], 4'h0, 6'h00, 2'h2, 4'b0010});
    rc(0, `OFF_RESULT_HI, 32'h0000_0000);
    // Status is sticky but masked until enabled
    chk("irq_masked", o_irq, 1'b0);
    rc(0, `OFF_IRQ_STATUS, 32'h0000_0001);
    wr(0, `OFF_IRQ_ENABLE, 32'h0000_0001);
    chk("irq_on", o_irq, 1'b1);
    wr(0, `OFF_IRQ_CLEAR, 32'h0000_0001);
    chk("irq_off", o_irq, 1'b0);
    // Faults share one layout
    i_walk_access_fault <= 1'b1;
    walk(0, 1'b1, 1'b0);
    rc(0, `OFF_RESULT_LO, 32'h0000_0003);
    i_walk_access_fault <= 1'b0;
    i_walk_trans_fault <= 1'b1;
    walk(0, 1'b1, 1'b0);
    rc(0, `OFF_RESULT_LO, 32'h0000_0005);
    rc(0, `OFF_IRQ_STATUS, 32'h0000_0002);
    chk("irq_fault_masked", o_irq, 1'b0);
    // Long layouts, secure and non-secure banks
    i_walk_share <= 2'h2;
    i_walk_ns <= 1'b1;
    walk(1, 1'b0, 1'b0);
    rc(1, `OFF_RESULT_HI, {8'h4F, 16'h0000, pa_v[39:32]});
    rc(1, `OFF_RESULT_LO, {pa_v[31:12], 3'b101, 2'h2, 7'h00});
    rc(0, `OFF_RESULT_LO, 32'h0000_0005);
    walk(3, 1'b0, 1'b0);
    rc(3, `OFF_RESULT_LO, {pa_v[31:12], 3'b100, 2'h2, 7'h00});
    chk("irq_other_bank", o_irq, 1'b0);
    // Monitor mirrors
    rc(2, `OFF_AUTH_STATUS, i_mon_auth_status);
    wr(2, `OFF_AUTH_STATUS, 32'h0000_FFFF);
    rc(2, `OFF_AUTH_STATUS, i_mon_auth_status);
    wr(2, `OFF_EVENT_ID_LOW, 32'h0000_FFFF);
    rc(2, `OFF_EVENT_ID_LOW, i_mon_event_id_low);
    rc(2, `OFF_EVENT_ID_HIGH, i_mon_event_id_high);
    rc(3, `OFF_AUTH_STATUS, 32'h0000_0000);
    rc(3, `OFF_EVENT_ID_HIGH, 32'h0000_0000);
    // Software access to the result and an unmapped index
    wr(2, `OFF_RESULT_LO, 32'h1234_5000);
    wr(2, `OFF_RESULT_HI, 32'h0000_00AB);
    rc(2, `OFF_RESULT_LO, 32'h1234_5000);
    rc(2, `OFF_RESULT_HI, 32'h0000_00AB);
    wr(2, 4'hA, 32'hFFFF_FFFF);
    rc(2, 4'hA, 32'h0000_0000);
    test_done();
  end
endmodule // tb_top
